/* core/bbf_host.sv */
// bbf_host: host-side strobe sequencer for a byte-wide boot block flash
// assumes the flash pins are wired directly; the data bus is resolved outside
`timescale 1ns/1ps
module bbf_host (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic REQ_VALID,
	input wire logic [1:0] REQ_OP,
	input wire logic [bbf_pkg::ADDR_W-1:0] REQ_ADDR,
	input wire logic [bbf_pkg::DATA_W-1:0] REQ_DATA,
	input wire logic REQ_PROTECT_BOOT,
	output logic REQ_READY,
	output logic RSP_VALID,
	output logic [bbf_pkg::DATA_W-1:0] RSP_DATA,
	output logic [bbf_pkg::BLK_W-1:0] RSP_BLOCK,
	output logic [bbf_pkg::ADDR_W-1:0] FL_ADDR,
	input wire logic [bbf_pkg::DATA_W-1:0] FL_DQ_I,
	output logic [bbf_pkg::DATA_W-1:0] FL_DQ_O,
	output logic FL_DQ_OE,
	output logic FL_CE_N,
	output logic FL_OE_N,
	output logic FL_WE_N,
	output logic FL_WP_N,
	output logic FL_RESET_POWERDOWN_N
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	bbf_pkg::bbf_state_t state_q;
	logic [bbf_pkg::CNT_W-1:0] cnt_q;
	logic [bbf_pkg::CNT_W-1:0] wake_q;
	logic [bbf_pkg::DATA_W-1:0] dq_sync;
	logic [bbf_pkg::DATA_W-1:0] old_q;
	logic [bbf_pkg::BLK_W-1:0] blk_d;
	logic take_d;
	bbf_sync #(
		.W(bbf_pkg::DATA_W)
	) u_dq_sync (
		.clk(SYS_CLK),
		.arst_n(ARST_N),
		.din(FL_DQ_I),
		.dout(dq_sync)
	);
	// ------------------------------------------------------------
	// block map, bottom boot
	// ------------------------------------------------------------
	always_comb begin
		if (REQ_ADDR[bbf_pkg::ADDR_W-1:bbf_pkg::MAIN_SHIFT] == '0) begin
			blk_d = bbf_pkg::BLK_W'(REQ_ADDR[bbf_pkg::MAIN_SHIFT-1:bbf_pkg::SMALL_SHIFT]);
		end else begin
			blk_d = bbf_pkg::BLK_W'(REQ_ADDR[bbf_pkg::ADDR_W-1:bbf_pkg::MAIN_SHIFT])
				+ bbf_pkg::BLK_W'(bbf_pkg::SMALL_BLOCKS - 1);
		end
	end
	// ------------------------------------------------------------
	// request take
	// ------------------------------------------------------------
	always_comb begin
		take_d = state_q == bbf_pkg::ST_IDLE && REQ_VALID && REQ_READY;
	end
	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_q <= bbf_pkg::ST_BOOT;
			cnt_q <= '0;
		end else begin
			unique case (state_q)
				bbf_pkg::ST_BOOT: begin
					if (cnt_q == bbf_pkg::CNT_W'(bbf_pkg::RESET_LOW_CYC - 1)) begin
						state_q <= bbf_pkg::ST_IDLE;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				bbf_pkg::ST_IDLE: begin
					cnt_q <= '0;
					if (take_d) begin
						unique case (REQ_OP)
							bbf_pkg::OP_READ: state_q <= bbf_pkg::ST_READ;
							bbf_pkg::OP_RESET: state_q <= bbf_pkg::ST_RESET;
							bbf_pkg::OP_WRITE: state_q <= bbf_pkg::ST_WRITE;
							bbf_pkg::OP_MERGE: state_q <= bbf_pkg::ST_WRITE;
						endcase
					end
				end
				bbf_pkg::ST_RESET: begin
					if (cnt_q == bbf_pkg::CNT_W'(bbf_pkg::RESET_LOW_CYC - 1)) begin
						state_q <= bbf_pkg::ST_IDLE;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				bbf_pkg::ST_READ: begin
					// window closes once the synchronised byte is captured
					if (cnt_q == bbf_pkg::CNT_W'(bbf_pkg::STROBE_CYC + 3)) begin
						state_q <= bbf_pkg::ST_IDLE;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				bbf_pkg::ST_WRITE: begin
					// slot covers strobe, data hold and bus turnaround
					if (cnt_q == bbf_pkg::CNT_W'(bbf_pkg::STROBE_CYC + 3)) begin
						state_q <= bbf_pkg::ST_IDLE;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				default: begin
					// illegal one-hot code falls back to idle
					state_q <= bbf_pkg::ST_IDLE;
					cnt_q <= '0;
				end
			endcase
		end
	end
	// wake counter after reset release
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wake_q <= '0;
		end else if (state_q == bbf_pkg::ST_BOOT || state_q == bbf_pkg::ST_RESET) begin
			wake_q <= bbf_pkg::CNT_W'(bbf_pkg::RESET_TO_WRITE_CYC);
		end else if (wake_q != '0) begin
			wake_q <= wake_q - 1'b1;
		end
	end
	// ------------------------------------------------------------
	// pins
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			FL_RESET_POWERDOWN_N <= 1'b0;
			FL_CE_N <= 1'b1;
			FL_OE_N <= 1'b1;
			FL_WE_N <= 1'b1;
			FL_DQ_OE <= 1'b0;
			FL_DQ_O <= '0;
			FL_ADDR <= '0;
			FL_WP_N <= 1'b0;
		end else begin
			FL_RESET_POWERDOWN_N <= !(state_q == bbf_pkg::ST_BOOT
				|| state_q == bbf_pkg::ST_RESET);
			FL_WP_N <= !REQ_PROTECT_BOOT;
			if (take_d) begin
				FL_ADDR <= REQ_ADDR;
				FL_CE_N <= REQ_OP == bbf_pkg::OP_RESET;
				// merge keeps zeros already programmed as ones
				FL_DQ_O <= (REQ_OP == bbf_pkg::OP_MERGE) ? (REQ_DATA | ~old_q) : REQ_DATA;
			end else if (state_q == bbf_pkg::ST_READ) begin
				FL_OE_N <= !(cnt_q < bbf_pkg::CNT_W'(bbf_pkg::STROBE_CYC + 3));
			end else if (state_q == bbf_pkg::ST_WRITE) begin
				FL_DQ_OE <= cnt_q < bbf_pkg::CNT_W'(bbf_pkg::STROBE_CYC + 1);
				FL_WE_N <= !(cnt_q < bbf_pkg::CNT_W'(bbf_pkg::STROBE_CYC));
			end else begin
				FL_CE_N <= 1'b1;
				FL_OE_N <= 1'b1;
				FL_WE_N <= 1'b1;
				FL_DQ_OE <= 1'b0;
			end
		end
	end
	// ------------------------------------------------------------
	// user answers
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			REQ_READY <= 1'b0;
			RSP_VALID <= 1'b0;
			RSP_DATA <= '0;
			RSP_BLOCK <= '0;
			old_q <= 8'hFF;
		end else begin
			REQ_READY <= state_q == bbf_pkg::ST_IDLE && wake_q <= 8'h01 && !REQ_VALID;
			RSP_VALID <= 1'b0;
			if (take_d) begin
				RSP_BLOCK <= blk_d;
			end
			if (state_q == bbf_pkg::ST_READ
				&& cnt_q == bbf_pkg::CNT_W'(bbf_pkg::STROBE_CYC + 3)) begin
				RSP_DATA <= dq_sync;
				old_q <= dq_sync;
				RSP_VALID <= 1'b1;
			end
			if ((state_q == bbf_pkg::ST_WRITE || state_q == bbf_pkg::ST_RESET)
				&& cnt_q == '0) begin
				RSP_VALID <= state_q == bbf_pkg::ST_WRITE;
			end
		end
	end
endmodule

/* core/bbf_pkg.sv */
// bbf_pkg: constants for the boot block flash host controller
// assumes a 100 MHz SYS_CLK and an asynchronous-strobe byte-wide flash
package bbf_pkg;
	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 20;
	localparam int DATA_W = 8;
	localparam int BLOCK_CNT = 23;
	localparam int SMALL_BLOCKS = 8;
	localparam int SMALL_SHIFT = 13;
	localparam int MAIN_SHIFT = 16;
	localparam int BLK_W = 5;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int STROBE_NS = 100;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_LOW_NS = 100;
	localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_TO_OUTPUT_NS = 150;
	localparam int RESET_TO_OUTPUT_CYC =
		(RESET_TO_OUTPUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_TO_WRITE_NS = 150;
	localparam int RESET_TO_WRITE_CYC =
		(RESET_TO_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	// ------------------------------------------------------------
	// user operations and sequencer states
	// ------------------------------------------------------------
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_RESET = 2'h2;
	localparam logic [1:0] OP_MERGE = 2'h3;
	typedef enum logic [4:0] {
		ST_BOOT = 5'h01,
		ST_IDLE = 5'h02,
		ST_READ = 5'h04,
		ST_WRITE = 5'h08,
		ST_RESET = 5'h10
	} bbf_state_t;
endpackage

/* core/bbf_sync.sv */
// bbf_sync: three-stage synchroniser with agreement filter
// assumes input is asynchronous to clk
`timescale 1ns/1ps
module bbf_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	// change counts once stages two and three agree
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dout <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					dout[i] <= s2_q[i];
				end
			end
		end
	end
endmodule

/* verification/bbf_host_chk.sv */
// bbf_host_chk: port-level assertions for bbf_host
// assumes it is bound onto the bbf_host ports
`timescale 1ns/1ps
module bbf_host_chk (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic REQ_VALID,
	input wire logic [1:0] REQ_OP,
	input wire logic REQ_PROTECT_BOOT,
	input wire logic REQ_READY,
	input wire logic RSP_VALID,
	input wire logic FL_DQ_OE,
	input wire logic FL_CE_N,
	input wire logic FL_OE_N,
	input wire logic FL_WE_N,
	input wire logic FL_WP_N,
	input wire logic FL_RESET_POWERDOWN_N
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	property p_wake; $rose(FL_RESET_POWERDOWN_N) |-> FL_CE_N [*8] ##1 FL_CE_N [*7]; endproperty
	a_wake: assert property (p_wake) else $error("flash selected inside wake time");
	property p_rst; $fell(FL_RESET_POWERDOWN_N) |-> !FL_RESET_POWERDOWN_N [*8] ##1 !FL_RESET_POWERDOWN_N; endproperty
	a_rst: assert property (p_rst) else $error("flash reset pulse short");
	property p_we; $fell(FL_WE_N) |-> !FL_WE_N [*8] ##1 !FL_WE_N [*2] ##1 FL_WE_N; endproperty
	a_we: assert property (p_we) else $error("write strobe width wrong");
	property p_hold; $rose(FL_WE_N) |-> FL_DQ_OE && !FL_CE_N; endproperty
	a_hold: assert property (p_hold) else $error("data released before strobe end");
	property p_dir; !FL_OE_N |-> !FL_DQ_OE && FL_WE_N; endproperty
	a_dir: assert property (p_dir) else $error("bus fight on data lines");
	property p_wp; $changed(REQ_PROTECT_BOOT) |-> ##[1:3] (FL_WP_N == !REQ_PROTECT_BOOT); endproperty
	a_wp: assert property (p_wp) else $error("protect pin not following request");
	property p_one; REQ_VALID && REQ_READY |=> !REQ_READY; endproperty
	a_one: assert property (p_one) else $error("second request taken at once");
	property p_wr; REQ_VALID && REQ_READY && REQ_OP == 2'h1 |-> ##2 RSP_VALID; endproperty
	a_wr: assert property (p_wr) else $error("write not answered");
endmodule
bind bbf_host bbf_host_chk chk_u (.*);

/* verification/bbf_flash_model.sv */
// bbf_flash_model: behavioural byte-wide boot block flash
// assumes strobes from bbf_host; erased bytes read 8'hFF
`timescale 1ns/1ps
module bbf_flash_model #(
	parameter int WAKE_NS = 150
) (
	input wire logic [19:0] addr,
	input wire logic [7:0] din,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic wp_n,
	input wire logic rp_n,
	output logic [7:0] dout
);
	logic [7:0] mem [0:1048575];
	logic [7:0] last_q = 8'h00;
	realtime wake_t = 0.0;
	function automatic logic [7:0] rd(logic [19:0] a);
		return mem[a];
	endfunction
	// whole array starts erased
	initial begin
		for (int i = 0; i < 1048576; i++) mem[i] = 8'hFF;
	end
	always @(posedge rp_n) wake_t = $realtime;
	// address and data latched at strobe end; programming only clears bits
	always @(posedge we_n) begin
		if (!ce_n && rp_n && $realtime - wake_t >= WAKE_NS && (wp_n || addr >= 20'h04000))
			mem[addr] = rd(addr) & din;
	end
	always @(posedge oe_n) last_q = rd(addr);
	// released bus shows the inverse of the last byte
	assign dout = (!ce_n && !oe_n && rp_n) ? rd(addr) : ~last_q;
endmodule

/* verification/bbf_host_tb.sv */
// bbf_host_tb: self-checking bench for the flash host controller
// assumes bbf_flash_model stands on the flash pins
`timescale 1ns/1ps
module bbf_host_tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic valid = 1'b0;
	logic [1:0] op_r = 2'h0;
	logic [19:0] addr_r = 20'h00000;
	logic [7:0] data_r = 8'h00;
	logic prot = 1'b0;
	logic ready, rsp_v, dq_oe, ce_n, oe_n, we_n, wp_n, rp_n;
	logic [7:0] rsp_d, dq_o, dq_i, m_dq, wr_seen;
	logic [4:0] blk;
	logic [19:0] fl_addr;
	int bad_count = 0;
	int checked = 0;
	always #5 clk = ~clk;
	assign dq_i = dq_oe ? dq_o : m_dq;
	always @(posedge we_n) wr_seen = dq_o;
	bbf_host dut_u (.SYS_CLK(clk), .ARST_N(arst_n), .REQ_VALID(valid), .REQ_OP(op_r),
		.REQ_ADDR(addr_r), .REQ_DATA(data_r), .REQ_PROTECT_BOOT(prot), .REQ_READY(ready),
		.RSP_VALID(rsp_v), .RSP_DATA(rsp_d), .RSP_BLOCK(blk), .FL_ADDR(fl_addr),
		.FL_DQ_I(dq_i), .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe), .FL_CE_N(ce_n), .FL_OE_N(oe_n),
		.FL_WE_N(we_n), .FL_WP_N(wp_n), .FL_RESET_POWERDOWN_N(rp_n));
	bbf_flash_model flash_u (.addr(fl_addr), .din(dq_o), .ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .wp_n(wp_n), .rp_n(rp_n), .dout(m_dq));
	task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// waits for ready (0) or the answer pulse (1), looked at after each edge
	task automatic wait_hi(input bit use_rsp);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
			if (n > 100) begin
				bad_count++;
				end_of_test();
			end
		end while ((use_rsp ? rsp_v : ready) !== 1'b1);
	endtask
	// one request, valid for one cycle after ready; waits for its answer except on reset
	task automatic req(logic [1:0] op, logic [19:0] a, logic [7:0] d);
		wait_hi(1'b0);
		@(posedge clk);
		valid <= 1'b1;
		op_r <= op;
		addr_r <= a;
		data_r <= d;
		@(posedge clk);
		valid <= 1'b0;
		if (op != 2'h2) wait_hi(1'b1);
	endtask
	task automatic t_basic();
		req(2'h1, 20'h10000, 8'h5A);
		req(2'h0, 20'h10000, 8'h00);
		chk("rd_main", rsp_d, 8'h5A);
		chk("blk_main", {3'h0, blk}, 8'h08);
		req(2'h0, 20'hF0000, 8'h00);
		chk("erased", rsp_d, 8'hFF);
		chk("blk_top", {3'h0, blk}, 8'h16);
		req(2'h0, 20'h02000, 8'h00);
		chk("blk_boot", {3'h0, blk}, 8'h01);
	endtask
	task automatic t_merge();
		req(2'h1, 20'h20000, 8'hBD);
		req(2'h0, 20'h20000, 8'h00);
		req(2'h3, 20'h20000, 8'hBC);
		req(2'h0, 20'h20000, 8'h00);
		chk("merge_pin", wr_seen, 8'hFE);
		chk("merge_rd", rsp_d, 8'hBC);
	endtask
	task automatic t_protect();
		@(posedge clk);
		prot <= 1'b1;
		req(2'h1, 20'h00010, 8'h00);
		chk("wp_pin", {7'h0, wp_n}, 8'h00);
		req(2'h0, 20'h00010, 8'h00);
		chk("boot_held", rsp_d, 8'hFF);
		@(posedge clk);
		prot <= 1'b0;
		req(2'h1, 20'h00010, 8'h00);
		req(2'h0, 20'h00010, 8'h00);
		chk("boot_open", rsp_d, 8'h00);
	endtask
	task automatic t_reset();
		req(2'h2, 20'h00000, 8'h00);
		req(2'h1, 20'h30000, 8'h3C);
		req(2'h0, 20'h30000, 8'h00);
		chk("wake_wr", rsp_d, 8'h3C);
		req(2'h0, 20'h10000, 8'h00);
		chk("rd_after_rst", rsp_d, 8'h5A);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		t_basic();
		t_merge();
		t_protect();
		t_reset();
		end_of_test();
	end
endmodule
